/* File: core/usart_sync_slave_port.sv */
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`include "usart_sync_params.svh"

// Function
// - First queued word moves straight into shifter
// - Second word stays held, empty flag clear
// - Shifter done: load held word, set flag
// - Transmit interrupt enable wakes the core
// - Peripheral drives data pin only when input
// - Holding write with transmit enable starts transfer
// - Single-receive enable ignored in slave mode
// - Continuous receive keeps working during sleep
// - Complete word moves into FIFO, wakes core
// - Reception sets data-available flag, raises interrupt
// - Clearing continuous receive clears overrun error
// - Transmit status/control layout and reset value
// - Receive status/control layout and reset value
// - Flags bits five and four, same enables
// - Shift clock comes from the external pin
// - Receive data sampled on falling clock edge
// - Two-deep FIFO, overrun drops word, blocks
// - Data-available flag read-only, clears when empty
module usart_sync_slave_port #(
   parameter int ADDR_W = 12,
   parameter int RX_DEPTH = 2
) (
   input wire logic i_ref_clk, // Core clock
   input wire logic i_srst, // Synchronous reset, active high
   input wire logic i_hsel, // AHB slave select
   input wire logic [ADDR_W-1:0] i_haddr, // AHB byte address
   input wire logic [1:0] i_htrans, // AHB transfer type
   input wire logic i_hwrite, // AHB write
   input wire logic [2:0] i_hsize, // AHB size, word only
   input wire logic [31:0] i_hwdata, // AHB write data
   input wire logic i_hready, // AHB bus ready
   output logic o_hreadyout, // AHB slave ready
   output logic [31:0] o_hrdata, // AHB read data
   output logic o_hresp, // AHB response, always OKAY
   input wire usart_sync_pkg::pin_pair_t i_pins, // Clock and data pin levels
   input wire logic [1:0] i_port_dir, // Pin directions, 1 = input
   output logic o_data_out, // Data pin output level
   output logic o_data_oe, // Data pin output enable
   output logic o_core_wake // Interrupt request, wakes core
);
   import usart_sync_pkg::*;

   localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
   localparam logic [7:0] TX_CTRL_RST = `USS_TX_CTRL_RST;
   localparam logic [7:0] RX_CTRL_RST = `USS_RX_CTRL_RST;

   // Decoder needs ten address bits; pointers must wrap cleanly
   if (ADDR_W < 10 || RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_param
      $error("ADDR_W must be at least 10, RX_DEPTH a power of two of at least 2");
   end

   // Byte address of a register index
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      return a == ADDR_W'({idx, 2'b00});
   endfunction

   // Index of the last bit of a word
   function automatic logic [3:0] last_bit(input logic nine);
      return nine ? `USS_LAST_BIT_9 : `USS_LAST_BIT_8;
   endfunction

   // Bus state
   logic acc_q, wr_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0] rdata;
   // Control registers
   logic clock_source_select_q, nine_bit_transmit_q, transmit_enable_q, sync_select_q;
   logic high_baud_select_q, ninth_transmit_bit_q, serial_port_enable_q, nine_bit_receive_q;
   logic single_receive_enable_q, continuous_receive_enable_q, address_detect_enable_q;
   logic overrun_error_q;
   logic [7:0] irq_enables_q, baud_divisor_q;
   // Transmit holding stage
   logic [7:0] transmit_holding_q;
   logic hold_full_q;
   tx_state_t tx_state_q;
   // Shift registers and their bit counters
   logic [8:0] transmit_shift_reg_q, receive_shift_reg_q;
   logic [3:0] tx_cnt_q, rx_cnt_q;
   // Receive FIFO
   rx_word_t rx_fifo_q [RX_DEPTH];
   logic [PW-1:0] wr_ptr_q, rd_ptr_q;
   logic [PW:0] rx_count_q;
   // Pin synchronisers
   pin_pair_t pin_s1_q, pin_s2_q;
   logic clk_s3_q;

   // Two flops on the pins, then an edge flop on the second stage
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         clk_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= i_pins;
         pin_s2_q <= pin_s1_q;
         clk_s3_q <= pin_s2_q.clk;
      end
   end

   logic clk_fall, slave_mode, tx_run, rx_on, wr_stb, rd_stb, take, tx_load, rx_done;
   logic [8:0] rsr_next;
   logic fifo_full, fifo_empty, rx_avail, tx_empty_flag, push, pop;
   rx_word_t rx_head, rx_word;

   // Shift clock is the external pin, edges found on the core clock
   assign clk_fall = clk_s3_q & ~pin_s2_q.clk;
   assign slave_mode = serial_port_enable_q & sync_select_q & ~clock_source_select_q;
   // Receive owns the shared pin when continuous receive is on
   assign tx_run = transmit_enable_q & slave_mode & ~continuous_receive_enable_q;
   assign rx_on = slave_mode & continuous_receive_enable_q;
   assign take = i_hsel & i_htrans[1] & i_hready;
   assign wr_stb = acc_q & wr_q;
   assign rd_stb = acc_q & ~wr_q;
   assign fifo_full = rx_count_q == (PW+1)'(RX_DEPTH);
   assign fifo_empty = rx_count_q == '0;
   assign rx_head = rx_fifo_q[rd_ptr_q];
   // Flags are derived state; a write to the flag register never reaches them
   assign rx_avail = ~fifo_empty;
   assign tx_empty_flag = transmit_enable_q & ~hold_full_q;
   assign tx_load = (tx_state_q == TX_IDLE) & hold_full_q & tx_run;
   assign rsr_next = {pin_s2_q.data, receive_shift_reg_q[8:1]};
   // Overrun blocks shifting until software clears it
   assign rx_done = clk_fall & rx_on & ~overrun_error_q
      & (rx_cnt_q == last_bit(nine_bit_receive_q));
   assign rx_word.ninth = nine_bit_receive_q & rsr_next[8];
   assign rx_word.data = nine_bit_receive_q ? rsr_next[7:0] : rsr_next[8:1];

   // Address phase is taken here; the data phase gets one wait state
   // so a read right after a write always sees the written value
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         acc_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= '0;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         acc_q <= take;
         o_hresp <= 1'b0;
         if (take) begin
            wr_q <= i_hwrite;
            addr_q <= i_haddr;
            o_hreadyout <= 1'b0;
         end else if (acc_q) begin
            o_hreadyout <= 1'b1;
         end
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      rdata = 8'h00;
      if (hit(addr_q, `USS_IDX_IRQ_FLAGS)) begin
         rdata[`USS_IRQ_RX_BIT] = rx_avail;
         rdata[`USS_IRQ_TX_BIT] = tx_empty_flag;
      end else if (hit(addr_q, `USS_IDX_IRQ_EN)) begin
         rdata = irq_enables_q;
      end else if (hit(addr_q, `USS_IDX_RX_CTRL)) begin
         rdata[`USS_RC_PORT_EN] = serial_port_enable_q;
         rdata[`USS_RC_NINE] = nine_bit_receive_q;
         rdata[`USS_RC_SINGLE] = single_receive_enable_q;
         rdata[`USS_RC_CONT] = continuous_receive_enable_q;
         rdata[`USS_RC_ADDR_DET] = address_detect_enable_q;
         rdata[`USS_RC_FRAME_ERR] = 1'b0; // No framing in sync mode
         rdata[`USS_RC_OVERRUN] = overrun_error_q;
         rdata[`USS_RC_NINTH] = rx_head.ninth & ~fifo_empty;
      end else if (hit(addr_q, `USS_IDX_RX_HEAD)) begin
         rdata = fifo_empty ? 8'h00 : rx_head.data;
      end else if (hit(addr_q, `USS_IDX_TX_CTRL)) begin
         rdata[`USS_TC_CLK_SRC] = clock_source_select_q;
         rdata[`USS_TC_NINE] = nine_bit_transmit_q;
         rdata[`USS_TC_ENABLE] = transmit_enable_q;
         rdata[`USS_TC_SYNC] = sync_select_q;
         rdata[`USS_TC_HIGH_BAUD] = high_baud_select_q;
         rdata[`USS_TC_SHIFT_EMPTY] = tx_state_q == TX_IDLE;
         rdata[`USS_TC_NINTH] = ninth_transmit_bit_q;
      end else if (hit(addr_q, `USS_IDX_BAUD)) begin
         rdata = baud_divisor_q;
      end
   end

   // Read data held until the next read
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_hrdata <= 32'h0000_0000;
      end else if (rd_stb) begin
         o_hrdata <= {24'h00_0000, rdata};
      end
   end

   // Software-written control bits; write-only holding is separate
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         {clock_source_select_q, nine_bit_transmit_q, transmit_enable_q, sync_select_q}
            <= TX_CTRL_RST[`USS_TC_CLK_SRC:`USS_TC_SYNC];
         high_baud_select_q <= TX_CTRL_RST[`USS_TC_HIGH_BAUD];
         ninth_transmit_bit_q <= TX_CTRL_RST[`USS_TC_NINTH];
         {serial_port_enable_q, nine_bit_receive_q, single_receive_enable_q,
            continuous_receive_enable_q, address_detect_enable_q}
            <= RX_CTRL_RST[`USS_RC_PORT_EN:`USS_RC_ADDR_DET];
         irq_enables_q <= `USS_IRQ_EN_RST;
         baud_divisor_q <= `USS_BAUD_RST;
      end else if (wr_stb) begin
         if (hit(addr_q, `USS_IDX_TX_CTRL)) begin
            clock_source_select_q <= i_hwdata[`USS_TC_CLK_SRC];
            nine_bit_transmit_q <= i_hwdata[`USS_TC_NINE];
            transmit_enable_q <= i_hwdata[`USS_TC_ENABLE];
            sync_select_q <= i_hwdata[`USS_TC_SYNC];
            high_baud_select_q <= i_hwdata[`USS_TC_HIGH_BAUD];
            ninth_transmit_bit_q <= i_hwdata[`USS_TC_NINTH];
         end
         if (hit(addr_q, `USS_IDX_RX_CTRL)) begin
            serial_port_enable_q <= i_hwdata[`USS_RC_PORT_EN];
            nine_bit_receive_q <= i_hwdata[`USS_RC_NINE];
            single_receive_enable_q <= i_hwdata[`USS_RC_SINGLE];
            continuous_receive_enable_q <= i_hwdata[`USS_RC_CONT];
            address_detect_enable_q <= i_hwdata[`USS_RC_ADDR_DET];
         end
         if (hit(addr_q, `USS_IDX_IRQ_EN)) begin
            irq_enables_q <= i_hwdata[7:0];
         end
         if (hit(addr_q, `USS_IDX_BAUD)) begin
            baud_divisor_q <= i_hwdata[7:0];
         end
      end
   end

   // Holding register; a new write wins over a same-cycle transfer out
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         transmit_holding_q <= `USS_HOLD_RST;
         hold_full_q <= 1'b0;
      end else begin
         if (tx_load) begin
            hold_full_q <= 1'b0;
         end
         if (wr_stb && hit(addr_q, `USS_IDX_TX_HOLD)) begin
            transmit_holding_q <= i_hwdata[7:0];
            hold_full_q <= 1'b1;
         end
      end
   end

   // Transmit shifter: the ninth bit is taken as it stands at load,
   // bits leave LSB first and advance after each falling clock edge
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         tx_state_q <= TX_IDLE;
         transmit_shift_reg_q <= 9'h000;
         tx_cnt_q <= 4'h0;
      end else begin
         unique case (tx_state_q)
            TX_IDLE: begin
               if (tx_load) begin
                  transmit_shift_reg_q <= {ninth_transmit_bit_q, transmit_holding_q};
                  tx_cnt_q <= 4'h0;
                  tx_state_q <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (!tx_run) begin
                  tx_state_q <= TX_IDLE;
               end else if (clk_fall) begin
                  transmit_shift_reg_q <= {1'b0, transmit_shift_reg_q[8:1]};
                  tx_cnt_q <= tx_cnt_q + 4'h1;
                  if (tx_cnt_q == last_bit(nine_bit_transmit_q)) begin
                     tx_state_q <= TX_IDLE;
                  end
               end
            end
            default: begin
               tx_state_q <= TX_IDLE;
            end
         endcase
      end
   end

   // Data pin drive, only while shifting and both pins are set as input
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_data_out <= 1'b0;
         o_data_oe <= 1'b0;
      end else begin
         o_data_out <= transmit_shift_reg_q[0];
         o_data_oe <= (tx_state_q == TX_SHIFT) & tx_run & (&i_port_dir);
      end
   end

   // Receive shifter samples on the falling edge of the shift clock
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         receive_shift_reg_q <= 9'h000;
         rx_cnt_q <= 4'h0;
      end else if (!rx_on || overrun_error_q) begin
         rx_cnt_q <= 4'h0;
      end else if (clk_fall) begin
         receive_shift_reg_q <= rsr_next;
         rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
      end
   end

   // Overrun: set on a word that finds the FIFO full, cleared with
   // continuous receive; the set can never meet the clear
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         overrun_error_q <= 1'b0;
      end else if (!continuous_receive_enable_q) begin
         overrun_error_q <= 1'b0;
      end else if (rx_done && fifo_full) begin
         overrun_error_q <= 1'b1;
      end
   end

   // Receive FIFO; a word that finds it full is dropped
   assign push = rx_done & ~fifo_full;
   assign pop = rd_stb & hit(addr_q, `USS_IDX_RX_HEAD) & ~fifo_empty;

   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         rx_fifo_q[wr_ptr_q] <= rx_word;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         rx_count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            rx_count_q <= rx_count_q + 1'b1;
         end else if (pop && !push) begin
            rx_count_q <= rx_count_q - 1'b1;
         end
      end
   end

   // Wake request from enabled flags; runs without any core activity
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_core_wake <= 1'b0;
      end else begin
         o_core_wake <= (rx_avail & irq_enables_q[`USS_IRQ_RX_BIT])
            | (tx_empty_flag & irq_enables_q[`USS_IRQ_TX_BIT]);
      end
   end

endmodule // usart_sync_slave_port

/* File: common/usart_sync_params.svh */
`ifndef USART_SYNC_PARAMS_SVH
`define USART_SYNC_PARAMS_SVH
// Register indices; the byte address is four times the index
`define USS_IDX_IRQ_FLAGS 8'h0c
`define USS_IDX_RX_CTRL 8'h18
`define USS_IDX_TX_HOLD 8'h19
`define USS_IDX_RX_HEAD 8'h1a
`define USS_IDX_IRQ_EN 8'h8c
`define USS_IDX_TX_CTRL 8'h98
`define USS_IDX_BAUD 8'h99
// Transmit status/control fields
`define USS_TC_CLK_SRC 7
`define USS_TC_NINE 6
`define USS_TC_ENABLE 5
`define USS_TC_SYNC 4
`define USS_TC_HIGH_BAUD 2
`define USS_TC_SHIFT_EMPTY 1
`define USS_TC_NINTH 0
// Receive status/control fields
`define USS_RC_PORT_EN 7
`define USS_RC_NINE 6
`define USS_RC_SINGLE 5
`define USS_RC_CONT 4
`define USS_RC_ADDR_DET 3
`define USS_RC_FRAME_ERR 2
`define USS_RC_OVERRUN 1
`define USS_RC_NINTH 0
// Interrupt flag / enable positions
`define USS_IRQ_RX_BIT 5
`define USS_IRQ_TX_BIT 4
// Reset values
`define USS_TX_CTRL_RST 8'h02
`define USS_RX_CTRL_RST 8'h00
`define USS_IRQ_EN_RST 8'h00
`define USS_BAUD_RST 8'h00
`define USS_HOLD_RST 8'h00
// Last bit index of a word
`define USS_LAST_BIT_8 4'h7
`define USS_LAST_BIT_9 4'h8
`endif

/* File: common/usart_sync_pkg.sv */
package usart_sync_pkg;
   // One received word as it sits in the receive FIFO
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } rx_word_t;
   // Clock pin and data pin sampled together
   typedef struct packed {
      logic clk;
      logic data;
   } pin_pair_t;
   // Transmit shifter state
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SHIFT = 2'b01
   } tx_state_t;
endpackage

/* File: bench/usart_sync_slave_port_assertions.sv */
`timescale 1ns/1ps
module usart_sync_slave_port_assertions #(
   parameter int ADDR_W = 12,
   parameter int RX_DEPTH = 2
) (
   input wire logic i_ref_clk, // Core clock
   input wire logic i_srst, // Reset
   input wire logic i_hsel, // Select
   input wire logic [ADDR_W-1:0] i_haddr, // Address
   input wire logic [1:0] i_htrans, // Type
   input wire logic i_hwrite, // Write
   input wire logic i_hready, // Bus ready
   input wire logic o_hreadyout, // Slave ready
   input wire logic [31:0] o_hrdata, // Read data
   input wire logic o_hresp, // Response
   input wire usart_sync_pkg::pin_pair_t i_pins, // Pin levels
   input wire logic [1:0] i_port_dir, // Directions
   input wire logic o_data_out, // Data level
   input wire logic o_data_oe, // Data enable
   input wire logic o_core_wake // Wake
);
   import usart_sync_pkg::*;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);
   wire logic take = i_hsel & i_htrans[1] & i_hready;
   logic clk_q, rd_q;
   logic [4:0] fall_q, wr_q;
   // Ages of the last pin fall and last write; saturate so old events fade
   always_ff @(posedge i_ref_clk) begin
      clk_q <= i_pins.clk;
      rd_q <= take & !i_hwrite & !i_srst;
      if (i_srst) fall_q <= 5'h1f;
      else if (clk_q & !i_pins.clk) fall_q <= 5'h00;
      else if (fall_q != 5'h1f) fall_q <= fall_q + 5'h01;
      if (i_srst) wr_q <= 5'h1f;
      else if (take & i_hwrite) wr_q <= 5'h00;
      else if (wr_q != 5'h1f) wr_q <= wr_q + 5'h01;
   end
   property p_wait; take |=> !o_hreadyout ##1 o_hreadyout; endproperty
   a_wait: assert property (p_wait) else $error("wait state wrong");
   property p_okay; take |=> !o_hresp [*2]; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_rdata; $changed(o_hrdata) |-> $past(rd_q); endproperty
   a_rdata: assert property (p_rdata) else $error("read data moved");
   property p_rst; $fell(i_srst) |-> o_hreadyout && !o_data_oe && !o_core_wake; endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle");
   property p_dir; o_data_oe |-> $past(i_port_dir) == 2'b11; endproperty
   a_dir: assert property (p_dir) else $error("drive without input dir");
   // A shift must lag the pin fall by the synchroniser, never lead it
   property p_shift; $changed(o_data_out) && $past(o_data_oe) |-> fall_q inside {[2:10]};
   endproperty
   a_shift: assert property (p_shift) else $error("shift off clock");
   property p_oe_off; $fell(o_data_oe) |-> fall_q <= 5'h0e; endproperty
   a_oe_off: assert property (p_oe_off) else $error("drive stop no fall");
   property p_wake; $rose(o_core_wake) |-> fall_q <= 5'h0e || wr_q <= 5'h06; endproperty
   a_wake: assert property (p_wake) else $error("wake no cause");
   c_tx: cover property ($rose(o_data_oe));
   c_wake: cover property ($rose(o_core_wake));
   c_read: cover property (take && !i_hwrite);
endmodule // usart_sync_slave_port_assertions

bind usart_sync_slave_port usart_sync_slave_port_assertions #(.ADDR_W(ADDR_W),
   .RX_DEPTH(RX_DEPTH)) i_chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_hsel(i_hsel),
   .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
   .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp), .i_pins(i_pins),
   .i_port_dir(i_port_dir), .o_data_out(o_data_out), .o_data_oe(o_data_oe),
   .o_core_wake(o_core_wake));

/* File: bench/sync_master_model.sv */
`timescale 1ns/1ps
module sync_master_model (
   input wire logic i_line, // Resolved data pin level
   output logic o_clk_pin, // Shift clock, idles high
   output logic o_drive // Our drive when the device is silent
);
   // Clock stands high between frames
   initial begin
      o_clk_pin = 1'b1;
      o_drive = 1'b0;
   end
   // LSB first; without drive the line toggles so stale levels never pass
   task automatic frame(input logic [8:0] w, input int n, input bit d, output logic [8:0] g);
      g = 9'h000;
      for (int i = 0; i < n; i++) begin
         o_drive = d ? w[i] : ~o_drive;
         #62.5 o_clk_pin = 1'b0;
         g[i] = i_line;
         #62.5 o_clk_pin = 1'b1;
      end
      #125 o_drive = ~o_drive;
   endtask
endmodule // sync_master_model

/* File: bench/usart_sync_slave_port_test.sv */
`timescale 1ns/1ps
`include "usart_sync_params.svh"
module usart_sync_slave_port_test;
   import usart_sync_pkg::*;
   logic clk, srst, hsel, hwrite, mclk, drv, line, hreadyout, hresp, data_out, data_oe, wake;
   logic [11:0] haddr;
   logic [1:0] htrans, port_dir;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, seed;
   logic [7:0] w1, w2, w3;
   logic [8:0] got;
   pin_pair_t pins;
   int errors, num_checks;
   // The data pin resolves between device and master
   assign line = data_oe ? data_out : drv;
   assign pins = {mclk, line};
   usart_sync_slave_port i_usart_sync_slave_port (.i_ref_clk(clk), .i_srst(srst),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hrdata(hrdata),
      .o_hresp(hresp), .i_pins(pins), .i_port_dir(port_dir), .o_data_out(data_out),
      .o_data_oe(data_oe), .o_core_wake(wake));
   sync_master_model i_sync_master_model (.i_line(line), .o_clk_pin(mclk), .o_drive(drv));
   // Core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] exp_flags(input logic rx, input logic tx);
      return {2'b00, rx, tx, 4'h0};
   endfunction
   task automatic rnd(output logic [7:0] v);
      seed = xorshift(seed);
      v = seed[7:0];
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %0t: register got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk9(input logic [8:0] g, input logic [8:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %0t: link word got %h expected %h", $time, g, e);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // One single transfer; wait states are bounded, not assumed
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
      output logic [7:0] r);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {2'b00, idx, 2'b00};
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      r = hrdata[7:0];
      if (n >= 40) begin
         errors++;
         finish_test();
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, idx, d, r);
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] r;
      bus(1'b0, idx, 8'h00, r);
      chk8(r, e);
   endtask
   task automatic link(input logic [8:0] w, input int n, input bit d);
      i_sync_master_model.frame(w, n, d, got);
      @(posedge clk);
   endtask
   // Watchdog against a hung run
   initial begin
      #200000;
      errors++;
      finish_test();
   end
   initial begin
      errors = 0;
      num_checks = 0;
      seed = 32'h0000_0015;
      srst = 1'b1;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      haddr = 12'h000;
      hsize = 3'h2;
      hwdata = 32'h0;
      port_dir = 2'b11;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rchk(`USS_IDX_TX_CTRL, `USS_TX_CTRL_RST);
      rchk(`USS_IDX_RX_CTRL, `USS_RX_CTRL_RST);
      rchk(`USS_IDX_IRQ_EN, `USS_IRQ_EN_RST);
      wr(`USS_IDX_IRQ_FLAGS, 8'hff);
      rchk(`USS_IDX_IRQ_FLAGS, exp_flags(0, 0));
      wr(8'h40, 8'h5a);
      rchk(8'h40, 8'h00);
      wr(`USS_IDX_TX_CTRL, 8'h08);
      rchk(`USS_IDX_TX_CTRL, 8'h02);
      $display("test registers done");
      wr(`USS_IDX_RX_CTRL, 8'h80);
      wr(`USS_IDX_TX_CTRL, 8'h30);
      wr(`USS_IDX_IRQ_EN, 8'h10);
      rchk(`USS_IDX_IRQ_FLAGS, exp_flags(0, 1));
      chk8({7'h0, wake}, 8'h01);
      repeat (3) begin
         rnd(w1);
         rnd(w2);
         wr(`USS_IDX_TX_HOLD, w1);
         wr(`USS_IDX_TX_HOLD, w2);
         rchk(`USS_IDX_IRQ_FLAGS, exp_flags(0, 0));
         rchk(`USS_IDX_TX_CTRL, 8'h30);
         chk8({7'h0, wake}, 8'h00);
         link(9'h000, 8, 0);
         chk9(got, {1'b0, w1});
         rchk(`USS_IDX_IRQ_FLAGS, exp_flags(0, 1));
         link(9'h000, 8, 0);
         chk9(got, {1'b0, w2});
      end
      rchk(`USS_IDX_TX_CTRL, 8'h32);
      wr(`USS_IDX_TX_CTRL, 8'h71);
      rnd(w1);
      wr(`USS_IDX_TX_HOLD, w1);
      link(9'h000, 9, 0);
      chk9(got, {1'b1, w1});
      // Drive waits until both pins are set as inputs
      port_dir <= 2'b01;
      rnd(w2);
      wr(`USS_IDX_TX_HOLD, w2);
      repeat (3) @(posedge clk);
      chk8({7'h0, data_oe}, 8'h00);
      port_dir <= 2'b11;
      repeat (3) @(posedge clk);
      chk8({7'h0, data_oe}, 8'h01);
      link(9'h000, 9, 0);
      chk9(got, {1'b1, w2});
      $display("test transmit done");
      wr(`USS_IDX_TX_CTRL, 8'h10);
      wr(`USS_IDX_IRQ_EN, 8'h20);
      wr(`USS_IDX_RX_CTRL, 8'ha0);
      link({1'b0, w1}, 8, 1);
      rchk(`USS_IDX_IRQ_FLAGS, exp_flags(0, 0));
      wr(`USS_IDX_RX_CTRL, 8'hb0);
      rnd(w1);
      rnd(w2);
      rnd(w3);
      link({1'b0, w1}, 8, 1);
      rchk(`USS_IDX_IRQ_FLAGS, exp_flags(1, 0));
      chk8({7'h0, wake}, 8'h01);
      link({1'b0, w2}, 8, 1);
      link({1'b0, w3}, 8, 1);
      rchk(`USS_IDX_RX_CTRL, 8'hb2);
      rchk(`USS_IDX_RX_HEAD, w1);
      rchk(`USS_IDX_IRQ_FLAGS, exp_flags(1, 0));
      rchk(`USS_IDX_RX_HEAD, w2);
      rchk(`USS_IDX_IRQ_FLAGS, exp_flags(0, 0));
      wr(`USS_IDX_RX_CTRL, 8'ha0);
      rchk(`USS_IDX_RX_CTRL, 8'ha0);
      wr(`USS_IDX_RX_CTRL, 8'hf0);
      rnd(w1);
      link({1'b1, w1}, 9, 1);
      rchk(`USS_IDX_RX_CTRL, 8'hf1);
      rchk(`USS_IDX_RX_HEAD, w1);
      $display("test receive done");
      finish_test();
   end
endmodule // usart_sync_slave_port_test
